// *** hdl/slc_sleep_ctrl.sv ***
// sleep controller: active mode plus idle, standby and power-down
// assumes an apb master on pclk and a processor core on the same clock;
// wake requests, break and oscillator status come from other domains
//
// Operation
// - One active mode; idle, standby, power-down each entered from active.
// - Any sleep state halts the processor until wake-up or reset.
// - Interrupt wake: handler runs, then execution resumes after sleep.
// - Any reset ends sleep and restarts from the reset vector.
// - Register file, memory and peripheral registers are kept in sleep.
// - Only a sleep instruction with sleep enabled starts sleep.
// - With no interrupt enabled, only a debugger break or reset ends sleep.
// - Idle stops only the processor; every interrupt can wake.
// - Standby stops fast clocks unless run_in_standby; subset wakes.
// - Power-down stops all fast clocks; few peripherals; subset wakes.
// - The hot_leakage_cut bit cuts power-down leakage further.
// - Automatic regulator goes low current asleep on 32k oscillator only; here standby and power-down go low on any clock.
// - Automatic: low in standby, power-down and idle on 32k only, else full; full: always full.
// - Always-on group runs in all sleeps; logic per standby; rest idle only.
// - Idle wake takes six cycles; deeper sleeps wait for clock, regulator.
// - A debugger break wakes the device with no interrupt pending.
// - Regulator register writes need the key within four instructions.
`timescale 1ns/1ps
module slc_sleep_ctrl
  import slc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor core
  input wire logic sleep_instr,
  input wire logic instr_step,
  input wire logic global_irq_en,
  input wire logic [NIRQ-1:0] irq_enable,
  output logic cpu_halt,
  output logic resume_pulse,
  // asynchronous wake sources and status
  input wire logic [NIRQ-1:0] irq_req,
  input wire logic debug_break,
  input wire logic osc_ready,
  input wire logic regulator_ready,
  input wire logic internal_32k_oscillator_only,
  // run in standby requests from peripherals and clock sources
  input wire logic [NRUN-1:0] run_in_standby,
  // clock and power control
  output logic hf_clk_run,
  output logic ccl_run,
  output logic per_run,
  output logic aon_run,
  output logic reg_low_power,
  output logic leak_cut_on,
  output logic retain
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    slc_state_t state;
    logic [1:0] sleep_mode_select;
    logic sleep_enable_bit;
    logic regulator_power_select;
    logic hlc;
    logic [1:0] slept_mode;
    logic [2:0] cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_halt;
    logic resume;
    logic hf_run;
    logic ccl_run;
    logic per_run;
    logic aon_run;
    logic lowp;
    logic leak;
  } slc_core_t;

  slc_core_t s_reg;
  slc_core_t s_next;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NIRQ+3:0] sync_q;
  logic [NIRQ-1:0] irq_s;
  logic brk_s;
  logic osc_rdy_s;
  logic reg_rdy_s;
  logic only32k_s;

  slc_sync #(
    .W(NIRQ + 4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({internal_32k_oscillator_only, regulator_ready, osc_ready, debug_break, irq_req}),
    .sync_out(sync_q)
  );

  assign irq_s = sync_q[NIRQ-1:0];
  assign brk_s = sync_q[NIRQ];
  assign osc_rdy_s = sync_q[NIRQ+1];
  assign reg_rdy_s = sync_q[NIRQ+2];
  assign only32k_s = sync_q[NIRQ+3];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr_acc;
  logic key_wr;
  logic vreg_wr;
  logic unlock_open;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && s_reg.pready && pwrite;
  assign key_wr = wr_acc && paddr == OFS_UNLOCK && pwdata[7:0] == UNLOCK_KEY;
  assign vreg_wr = wr_acc && paddr == OFS_VREG && unlock_open;

  slc_unlock u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(key_wr),
    .instr_step(instr_step),
    .prot_wr(vreg_wr),
    .open(unlock_open)
  );

  // ----------------------------------------------------------------
  // wake qualification
  // ----------------------------------------------------------------
  logic [NIRQ-1:0] permit;
  logic irq_wake;
  logic asleep;
  logic deep;

  // allowed sources per sleep state
  always_comb begin
    case (s_reg.state)
      ST_IDLE: permit = WAKE_IDLE;
      ST_STDBY: permit = WAKE_STDBY;
      ST_PDOWN: permit = s_reg.hlc ? WAKE_PDOWN_HLC : WAKE_PDOWN;
      default: permit = '0;
    endcase
  end

  // enabled and permitted requests only; none enabled means sleep holds
  assign irq_wake = global_irq_en && |(irq_s & irq_enable & permit);
  assign asleep = s_reg.state == ST_IDLE || s_reg.state == ST_STDBY
    || s_reg.state == ST_PDOWN;
  assign deep = s_reg.slept_mode != SLEEP_MODE_SELECT_IDLE;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.resume = 1'b0;

    // apb: answer registered in the access cycle, one cycle after setup
    s_next.pready = setup;
    s_next.pslverr = 1'b0;
    if (setup) begin
      s_next.prdata = '0;
      case (paddr)
        OFS_CONTROL_A_REGISTER: begin
          s_next.prdata[SLEEP_MODE_SELECT_LSB +: 2] = s_reg.sleep_mode_select;
          s_next.prdata[SEN_BIT] = s_reg.sleep_enable_bit;
        end
        OFS_VREG: begin
          s_next.prdata[REGULATOR_POWER_SELECT_BIT] = s_reg.regulator_power_select;
          s_next.prdata[HLC_BIT] = s_reg.hlc;
        end
        OFS_UNLOCK: s_next.prdata = '0;
        OFS_STATUS: begin
          s_next.prdata[ST_STATE_LSB +: 3] = s_reg.state;
          s_next.prdata[ST_UNLOCK_BIT] = unlock_open;
          s_next.prdata[ST_LOWP_BIT] = s_reg.lowp;
        end
        default: s_next.pslverr = 1'b1;
      endcase
    end else begin
      s_next.prdata = '0;
    end

    // configuration writes alone never start sleep
    if (wr_acc && paddr == OFS_CONTROL_A_REGISTER) begin
      s_next.sleep_mode_select = pwdata[SLEEP_MODE_SELECT_LSB +: 2];
      s_next.sleep_enable_bit = pwdata[SEN_BIT];
    end
    if (vreg_wr) begin
      s_next.regulator_power_select = pwdata[REGULATOR_POWER_SELECT_BIT];
      s_next.hlc = pwdata[HLC_BIT];
    end

    // sleep sequencing
    case (s_reg.state)
      ST_ACTIVE: begin
        if (sleep_instr && s_reg.sleep_enable_bit) begin
          s_next.slept_mode = s_reg.sleep_mode_select;
          s_next.cpu_halt = 1'b1;
          case (s_reg.sleep_mode_select)
            SLEEP_MODE_SELECT_STDBY: s_next.state = ST_STDBY;
            SLEEP_MODE_SELECT_PDOWN: s_next.state = ST_PDOWN;
            default: begin
              s_next.state = ST_IDLE;
              s_next.slept_mode = SLEEP_MODE_SELECT_IDLE;
            end
          endcase
        end
      end
      ST_IDLE, ST_STDBY, ST_PDOWN: begin
        // break wakes with nothing pending
        if (irq_wake || brk_s) begin
          s_next.state = deep ? ST_WAKE_CLK : ST_WAKE_CNT;
          s_next.cnt = WAKE_CYCLES;
        end
      end
      ST_WAKE_CLK: begin
        // deeper sleeps first wait for clock source and regulator
        if (osc_rdy_s && reg_rdy_s) begin
          s_next.state = ST_WAKE_CNT;
        end
      end
      ST_WAKE_CNT: begin
        s_next.cnt = s_reg.cnt - 3'h1;
        if (s_reg.cnt == 3'h1) begin
          // core takes the handler then continues after sleep
          s_next.state = ST_ACTIVE;
          s_next.cpu_halt = 1'b0;
          s_next.resume = 1'b1;
        end
      end
      default: begin
        s_next.state = ST_ACTIVE;
        s_next.cpu_halt = 1'b0;
      end
    endcase
    // mode field and enable bit untouched by wake-up

    // clock domain gating follows the state being entered
    case (s_next.state)
      ST_IDLE: begin
        s_next.hf_run = 1'b1;
        s_next.ccl_run = 1'b1;
        s_next.per_run = 1'b1;
      end
      ST_STDBY: begin
        s_next.hf_run = |run_in_standby;
        s_next.ccl_run = run_in_standby[RUN_CCL];
        s_next.per_run = 1'b0;
      end
      ST_PDOWN: begin
        s_next.hf_run = 1'b0;
        s_next.ccl_run = 1'b0;
        s_next.per_run = 1'b0;
      end
      ST_WAKE_CLK: begin
        s_next.hf_run = 1'b1;
        s_next.ccl_run = s_reg.ccl_run;
        s_next.per_run = 1'b0;
      end
      default: begin
        s_next.hf_run = 1'b1;
        s_next.ccl_run = 1'b1;
        s_next.per_run = 1'b1;
      end
    endcase
    s_next.aon_run = 1'b1;

    // regulator: automatic drops to low current asleep on 32k or in deep sleep
    if (s_reg.regulator_power_select == REGULATOR_POWER_SELECT_FULL) begin
      s_next.lowp = 1'b0;
    end else begin
      s_next.lowp = (asleep && only32k_s)
        || s_next.state == ST_STDBY || s_next.state == ST_PDOWN;
    end
    s_next.leak = s_reg.hlc && s_next.state == ST_PDOWN;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset drops any sleep state and restarts active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.state <= ST_ACTIVE;
      s_reg.sleep_mode_select <= SLEEP_MODE_SELECT_RST;
      s_reg.sleep_enable_bit <= SEN_RST;
      s_reg.regulator_power_select <= REGULATOR_POWER_SELECT_RST;
      s_reg.hlc <= HLC_RST;
      s_reg.slept_mode <= SLEEP_MODE_SELECT_IDLE;
      s_reg.cnt <= 3'h0;
      s_reg.prdata <= 32'h0000_0000;
      s_reg.pready <= 1'b0;
      s_reg.pslverr <= 1'b0;
      s_reg.cpu_halt <= 1'b0;
      s_reg.resume <= 1'b0;
      s_reg.hf_run <= 1'b1;
      s_reg.ccl_run <= 1'b1;
      s_reg.per_run <= 1'b1;
      s_reg.aon_run <= 1'b1;
      s_reg.lowp <= 1'b0;
      s_reg.leak <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign cpu_halt = s_reg.cpu_halt;
  assign resume_pulse = s_reg.resume;
  assign hf_clk_run = s_reg.hf_run;
  assign ccl_run = s_reg.ccl_run;
  assign per_run = s_reg.per_run;
  assign aon_run = s_reg.aon_run;
  assign reg_low_power = s_reg.lowp;
  assign leak_cut_on = s_reg.leak;
  // storage keeps contents in every state; retention held on
  assign retain = s_reg.aon_run;

endmodule : slc_sleep_ctrl

// *** hdl/slc_pkg.sv ***
// sleep controller package: register map, field layout, modes, timing
// assumes a 32-bit apb slave port on a single 40 MHz clock
package slc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_A_REGISTER = 8'h00;  // control_a_register
  localparam logic [7:0] OFS_VREG = 8'h04;   // regulator_control_register
  localparam logic [7:0] OFS_UNLOCK = 8'h08; // write_protect_unlock key
  localparam logic [7:0] OFS_STATUS = 8'h0C; // state readback

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SEN_BIT = 0;          // sleep_enable_bit
  localparam int SLEEP_MODE_SELECT_LSB = 1;        // sleep_mode_select [2:1]
  localparam int REGULATOR_POWER_SELECT_BIT = 0;        // regulator_power_select
  localparam int HLC_BIT = 4;          // hot_leakage_cut
  localparam int ST_STATE_LSB = 0;     // status: fsm state [2:0]
  localparam int ST_UNLOCK_BIT = 4;    // status: unlock window open
  localparam int ST_LOWP_BIT = 5;      // status: regulator low power
  localparam logic [1:0] SLEEP_MODE_SELECT_RST = 2'h0;
  localparam logic SEN_RST = 1'b0;
  localparam logic REGULATOR_POWER_SELECT_RST = 1'b0;
  localparam logic HLC_RST = 1'b0;

  // unlock key, value arbitrary
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;
  // protected write must follow within this many instructions
  localparam logic [2:0] UNLOCK_INSTR = 3'h4;

  // ----------------------------------------------------------------
  // modes and regulator settings
  // ----------------------------------------------------------------
  localparam logic [1:0] SLEEP_MODE_SELECT_IDLE = 2'h0;
  localparam logic [1:0] SLEEP_MODE_SELECT_STDBY = 2'h1;
  localparam logic [1:0] SLEEP_MODE_SELECT_PDOWN = 2'h2;
  localparam logic REGULATOR_POWER_SELECT_AUTO = 1'b0;
  localparam logic REGULATOR_POWER_SELECT_FULL = 1'b1;

  typedef enum logic [2:0] {
    ST_ACTIVE, ST_IDLE, ST_STDBY, ST_PDOWN, ST_WAKE_CLK, ST_WAKE_CNT
  } slc_state_t;

  // ----------------------------------------------------------------
  // wake sources: 0 pin, 1 brownout, 2 rtc, 3 two_wire match,
  // 4 configurable_logic, 5 serial start of frame, 6 timer a, 7 other
  // ----------------------------------------------------------------
  localparam int NIRQ = 8;
  localparam int IRQ_TWI = 3;
  localparam int IRQ_CCL = 4;
  localparam logic [7:0] WAKE_IDLE = 8'hFF;
  localparam logic [7:0] WAKE_STDBY = 8'h7F;
  localparam logic [7:0] WAKE_PDOWN = 8'h1F;
  localparam logic [7:0] WAKE_PDOWN_HLC = 8'h07;

  // standby run requests: 0 hf oscillator, 1 configurable_logic, 2 rtc
  localparam int NRUN = 3;
  localparam int RUN_CCL = 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [2:0] WAKE_CYCLES = 3'h6; // main clock cycles

endpackage : slc_pkg

// *** hdl/slc_sync.sv ***
// two flip-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level, held for several cycles
`timescale 1ns/1ps
module slc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } slc_sync_t;

  slc_sync_t s_reg;
  slc_sync_t s_next;

  // first stage is read only by the second
  always_comb begin
    s_next = s_reg;
    s_next.meta = async_in;
    s_next.stable = s_reg.meta;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;

endmodule : slc_sync

// *** hdl/slc_unlock.sv ***
// protection window for the regulator control register
// assumes instr_step pulses once per retired processor instruction
`timescale 1ns/1ps
module slc_unlock
  import slc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events
  input wire logic key_wr,
  input wire logic instr_step,
  input wire logic prot_wr,
  // window state
  output logic open
);

  typedef struct packed {
    logic [2:0] left;
  } slc_unlock_t;

  slc_unlock_t s_reg;
  slc_unlock_t s_next;

  // key opens the window; four instructions or the guarded write close it
  always_comb begin
    s_next = s_reg;
    if (prot_wr) begin
      s_next.left = 3'h0;
    end else if (instr_step && s_reg.left != 3'h0) begin
      s_next.left = s_reg.left - 3'h1;
    end
    if (key_wr) begin
      s_next.left = UNLOCK_INSTR;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign open = (s_reg.left != 3'h0);

endmodule : slc_unlock

// *** verification/slc_core_model.sv ***
// processor core stand-in: issues the sleep instruction and retires steps
// assumes bench command levels change just after a rising pclk edge
`timescale 1ns/1ps
module slc_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands and halt from the controller
  input wire logic do_sleep,
  input wire logic do_step,
  input wire logic cpu_halt,
  // core events
  output logic sleep_instr,
  output logic instr_step
);
  // a halted core neither retires instructions nor issues a sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
      instr_step <= 1'b0;
    end else begin
      sleep_instr <= do_sleep && !cpu_halt;
      instr_step <= do_step && !cpu_halt;
    end
  end
endmodule : slc_core_model

// *** verification/slc_sleep_ctrl_properties.sv ***
// concurrent checks on the sleep controller ports
// assumes one pclk domain with presetn as asynchronous active-low reset
`timescale 1ns/1ps
module slc_sleep_ctrl_properties
  import slc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // core and wake
  input wire logic sleep_instr,
  input wire logic cpu_halt,
  input wire logic resume_pulse,
  input wire logic debug_break,
  input wire logic [NRUN-1:0] run_in_standby,
  // clock and power control
  input wire logic hf_clk_run,
  input wire logic ccl_run,
  input wire logic per_run,
  input wire logic aon_run,
  input wire logic retain,
  input wire logic reg_low_power,
  input wire logic leak_cut_on
);
  logic sen_q;
  logic [1:0] mode_q;

  // shadow of enable and mode from completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_q <= SEN_RST;
      mode_q <= SLEEP_MODE_SELECT_RST;
    end else if (psel && penable && pready && pwrite && paddr == OFS_CONTROL_A_REGISTER) begin
      sen_q <= pwdata[SEN_BIT];
      mode_q <= pwdata[SLEEP_MODE_SELECT_LSB +: 2];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // sleep entry, refusal and resume
  property p_enter; sleep_instr && sen_q && !cpu_halt |=> cpu_halt; endproperty
  a_enter: assert property (p_enter) else $error("no halt after sleep");
  property p_refuse; sleep_instr && !sen_q && !cpu_halt |=> !cpu_halt; endproperty
  a_refuse: assert property (p_refuse) else $error("halt while disabled");
  property p_resume; $fell(cpu_halt) |-> resume_pulse ##1 !resume_pulse; endproperty
  a_resume: assert property (p_resume) else $error("resume pulse wrong");
  // clock gating per sleep state
  property p_idle;
    $rose(cpu_halt) && mode_q != SLEEP_MODE_SELECT_STDBY && mode_q != SLEEP_MODE_SELECT_PDOWN
      |-> hf_clk_run && per_run && ccl_run;
  endproperty
  a_idle: assert property (p_idle) else $error("idle stopped a clock");
  property p_stdby;
    $rose(cpu_halt) && mode_q == SLEEP_MODE_SELECT_STDBY |=> !per_run &&
      hf_clk_run == |run_in_standby && ccl_run == run_in_standby[RUN_CCL];
  endproperty
  a_stdby: assert property (p_stdby) else $error("standby gating wrong");
  property p_pdown;
    $rose(cpu_halt) && mode_q == SLEEP_MODE_SELECT_PDOWN |=> !hf_clk_run && !ccl_run && !per_run;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down clock on");
  property p_aon; presetn |-> aon_run && retain; endproperty
  a_aon: assert property (p_aon) else $error("always-on group stopped");
  property p_leak; leak_cut_on |-> cpu_halt; endproperty
  a_leak: assert property (p_leak) else $error("leak cut while awake");
  property p_lowp; reg_low_power |-> cpu_halt; endproperty
  a_lowp: assert property (p_lowp) else $error("low power while awake");
  property p_break; $rose(debug_break) && cpu_halt |-> ##[1:40] !cpu_halt; endproperty
  a_break: assert property (p_break) else $error("break did not wake");
endmodule : slc_sleep_ctrl_properties

bind slc_sleep_ctrl slc_sleep_ctrl_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .sleep_instr(sleep_instr),
  .cpu_halt(cpu_halt), .resume_pulse(resume_pulse), .debug_break(debug_break),
  .run_in_standby(run_in_standby), .hf_clk_run(hf_clk_run), .ccl_run(ccl_run),
  .per_run(per_run), .aon_run(aon_run), .retain(retain),
  .reg_low_power(reg_low_power), .leak_cut_on(leak_cut_on)
);

// *** verification/slc_sleep_ctrl_tb.sv ***
// self-checking bench for the sleep controller: apb, entry, gating, wake
// assumes the package, design, core model and checker compile first
`timescale 1ns/1ps
module slc_sleep_ctrl_tb;
  import slc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic global_irq_en = 1'b0, debug_break = 1'b0, osc_ready = 1'b1;
  logic regulator_ready = 1'b1, internal_32k_oscillator_only = 1'b0, do_sleep = 1'b0, do_step = 1'b0;
  logic [7:0] paddr = 8'h00, irq_enable = 8'h00, irq_req = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0] run_in_standby = 3'h0, rs;
  logic pready, pslverr, sleep_instr, instr_step, cpu_halt, resume_pulse;
  logic hf_clk_run, ccl_run, per_run, aon_run, reg_low_power, leak_cut_on, retain;
  logic [1:0] md;
  logic [4:0] er;
  logic [32:0] exp_q[$];
  int failures = 0, total_checks = 0, seed = 75, n, m;

  slc_sleep_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_instr(sleep_instr), .instr_step(instr_step), .global_irq_en(global_irq_en),
    .irq_enable(irq_enable), .cpu_halt(cpu_halt), .resume_pulse(resume_pulse),
    .irq_req(irq_req), .debug_break(debug_break), .osc_ready(osc_ready),
    .regulator_ready(regulator_ready), .internal_32k_oscillator_only(internal_32k_oscillator_only),
    .run_in_standby(run_in_standby), .hf_clk_run(hf_clk_run), .ccl_run(ccl_run),
    .per_run(per_run), .aon_run(aon_run), .reg_low_power(reg_low_power),
    .leak_cut_on(leak_cut_on), .retain(retain)
  );
  slc_core_model u_core (
    .pclk(pclk), .presetn(presetn), .do_sleep(do_sleep), .do_step(do_step),
    .cpu_halt(cpu_halt), .sleep_instr(sleep_instr), .instr_step(instr_step)
  );

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  // one apb transfer: setup, then access held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      failures++;
      finish_test();
    end
    // one idle edge, so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({a > OFS_STATUS, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task sleep_now;
    do_sleep <= 1'b1;
    @(posedge pclk);
    do_sleep <= 1'b0;
    cyc(3);
  endtask : sleep_now

  // edges until the resume pulse is sampled
  task wait_resume;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (resume_pulse !== 1'b1 && n < 60);
    if (n == 60) begin
      failures++;
      finish_test();
    end
  endtask : wait_resume

  // oldest read note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk("pslverr", 32'(exp_q[0][32]), 32'(pslverr));
      chk("prdata", exp_q[0][31:0], prdata);
      void'(exp_q.pop_front());
    end
  end

  initial begin
    cyc(4);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("run", 32'h1F, 32'({hf_clk_run, ccl_run, per_run, aon_run, retain}));
    chk("quiet", 32'h0, 32'({cpu_halt, resume_pulse, reg_low_power, leak_cut_on}));
    rd(OFS_CONTROL_A_REGISTER, 32'h0);
    rd(OFS_VREG, 32'h0);
    rd(OFS_UNLOCK, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(8'h10, 32'h0);
    wr(OFS_CONTROL_A_REGISTER, 32'h4);
    sleep_now();
    chk("halt", 32'h0, 32'(cpu_halt));
    global_irq_en <= 1'b1;
    irq_enable <= 8'hFF;
    // every mode code, random run requests in standby
    for (m = 0; m < 4; m++) begin
      rs = 3'($random(seed));
      run_in_standby <= rs;
      md = (m == 3) ? SLEEP_MODE_SELECT_IDLE : 2'(m);
      wr(OFS_CONTROL_A_REGISTER, 32'({2'(m), 1'b1}));
      sleep_now();
      chk("halt", 32'h1, 32'(cpu_halt));
      er = {md == SLEEP_MODE_SELECT_IDLE || (md == SLEEP_MODE_SELECT_STDBY && |rs), md == SLEEP_MODE_SELECT_IDLE ||
            (md == SLEEP_MODE_SELECT_STDBY && rs[RUN_CCL]), md == SLEEP_MODE_SELECT_IDLE, 2'h3};
      chk("run", 32'(er), 32'({hf_clk_run, ccl_run, per_run, aon_run, retain}));
      rd(OFS_STATUS, 32'({md != SLEEP_MODE_SELECT_IDLE, 2'h0, 3'(md + 2'h1)}));
      if (md == SLEEP_MODE_SELECT_PDOWN) begin
        osc_ready <= 1'b0;
        regulator_ready <= 1'b0;
        irq_req <= 8'h20;
        cyc(12);
        chk("halt", 32'h1, 32'(cpu_halt));
        irq_req <= 8'h01;
        cyc(12);
        chk("halt", 32'h1, 32'(cpu_halt));
        osc_ready <= 1'b1;
        cyc(12);
        chk("halt", 32'h1, 32'(cpu_halt));
        regulator_ready <= 1'b1;
      end else begin
        irq_req <= 8'h01;
      end
      wait_resume();
      // idle wakes in a fixed count; deeper sleeps also wait for start-up
      er = 5'(md == SLEEP_MODE_SELECT_IDLE ? n == 4 + WAKE_CYCLES : n >= 2 + WAKE_CYCLES);
      chk("wake", 32'h1, 32'(er));
      irq_req <= 8'h00;
      chk("halt", 32'h0, 32'(cpu_halt));
      rd(OFS_CONTROL_A_REGISTER, 32'({2'(m), 1'b1}));
    end
    // no interrupt enabled: only break or reset
    global_irq_en <= 1'b0;
    wr(OFS_CONTROL_A_REGISTER, 32'h1);
    sleep_now();
    irq_req <= 8'h01;
    cyc(20);
    chk("halt", 32'h1, 32'(cpu_halt));
    debug_break <= 1'b1;
    wait_resume();
    chk("halt", 32'h0, 32'(cpu_halt));
    debug_break <= 1'b0;
    irq_req <= 8'h00;
    sleep_now();
    chk("halt", 32'h1, 32'(cpu_halt));
    presetn <= 1'b0;
    cyc(2);
    chk("halt", 32'h0, 32'(cpu_halt));
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_CONTROL_A_REGISTER, 32'h0);
    // protected regulator register
    wr(OFS_VREG, 32'h11);
    rd(OFS_VREG, 32'h0);
    wr(OFS_UNLOCK, 32'(UNLOCK_KEY));
    rd(OFS_STATUS, 32'h10);
    wr(OFS_VREG, 32'h11);
    rd(OFS_VREG, 32'h11);
    wr(OFS_UNLOCK, 32'(UNLOCK_KEY));
    do_step <= 1'b1;
    cyc(5);
    do_step <= 1'b0;
    wr(OFS_VREG, 32'h0);
    rd(OFS_VREG, 32'h11);
    // full regulator with leakage cut in power-down
    global_irq_en <= 1'b1;
    irq_enable <= 8'hE7;
    wr(OFS_CONTROL_A_REGISTER, 32'h5);
    sleep_now();
    chk("lowp_leak", 32'h1, 32'({reg_low_power, leak_cut_on}));
    irq_req <= 8'h01;
    wait_resume();
    irq_req <= 8'h00;
    // automatic regulator on the 32k oscillator alone
    wr(OFS_UNLOCK, 32'(UNLOCK_KEY));
    wr(OFS_VREG, 32'h0);
    internal_32k_oscillator_only <= 1'b1;
    wr(OFS_CONTROL_A_REGISTER, 32'h1);
    sleep_now();
    chk("lowp", 32'h1, 32'(reg_low_power));
    irq_req <= 8'h01;
    wait_resume();
    cyc(1);
    chk("lowp", 32'h0, 32'(reg_low_power));
    finish_test();
  end
endmodule : slc_sleep_ctrl_tb
